// ==== hw/mss_consts.svh ====
// constants for the motion sleep and self-test controller
// assumes a 200 MHz core clock and a byte-wide register port
`ifndef MSS_CONSTS_SVH
`define MSS_CONSTS_SVH
`define MSS_ADDR_RATE      8'h2c
`define MSS_ADDR_INTSRC    8'h30
`define MSS_ADDR_FORMAT    8'h31
`define MSS_RATE_LOWPWR    4
`define MSS_FMT_SELFTEST   7
`define MSS_SRC_ACT        4
`define MSS_SRC_INACT      3
`define MSS_SRC_DRDY       7
`define MSS_RATE_RST       8'h0a
`define MSS_FORMAT_RST     8'h00
`define MSS_CLK_HZ         200000000
`define MSS_BASE_HZ        3200
`define MSS_BASE_DIV       (`MSS_CLK_HZ / `MSS_BASE_HZ)
`define MSS_SLEEP_HZ       8
`endif

// ==== hw/mss_ctrl.sv ====
// Overview of operation
// - lower rates decimate one shared sample stream
// - activity compares full-rate undecimated samples
// - link: activity armed only after inactivity
// - no autosleep while activity event pending
// - reduced power keeps ready flag
// - sleep+autosleep+link: sleep on inactivity
// - sleep entry: inactivity off, activity on
// - wake on activity, restore rate, flag event
// - after activity: activity off, inactivity on
// - format bit 7 applies self-test stimulus
// - sleep readings 8,4,2,1 Hz by wake code
//
// control core: register port, activity/inactivity link, autosleep
// assumes a byte register port on the core clock and a full-rate
// activity/inactivity comparator result supplied by the sensing path
`timescale 1ns/1ps
`default_nettype none
`include "mss_consts.svh"
module mss_ctrl #(
    parameter int unsigned BASE_DIV = `MSS_BASE_DIV
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       link_en,
    input  wire logic       autosleep_en,
    input  wire logic       sleep_en,
    input  wire logic [1:0] wakeup_code,
    input  wire logic       over_thresh,
    input  wire logic       still_timeout,
    output logic [7:0]      reg_rdata,
    output logic            sample_stb,
    output logic            asleep,
    output logic            selftest_force,
    output logic            act_armed,
    output logic            inact_armed
);
    logic [7:0]  rate_r;
    logic [7:0]  rate_nxt;
    logic [7:0]  fmt_r;
    logic [7:0]  fmt_nxt;
    logic [7:0]  src_r;
    logic [7:0]  src_nxt;
    logic [7:0]  rdata_nxt;
    logic        act_pend;
    logic        inact_pend;
    logic [31:0] base_cnt_r;
    logic [31:0] base_cnt_nxt;
    logic        base_stb;
    logic        out_stb;
    logic [11:0] ratio;
    logic [11:0] sleep_ratio;
    logic        stb_nxt;
    logic        act_hit;
    logic        inact_hit;
    mss_pkg::mss_state_t st_r;
    mss_pkg::mss_state_t st_nxt;

    assign act_pend   = src_r[`MSS_SRC_ACT];
    assign inact_pend = src_r[`MSS_SRC_INACT];

    // one shared full-rate stream; all lower rates tap it
    always_comb begin
        base_cnt_nxt = base_cnt_r + 32'h1;
        base_stb     = 1'b0;
        if (base_cnt_r >= BASE_DIV - 1) begin
            base_cnt_nxt = 32'h0;
            base_stb     = 1'b1;
        end
    end

    // rate code n gives 3200 / 2^(15-n), codes below 6 as code 6; sleep uses 8>>code
    // slowest sleep code needs a ratio of 3200, hence 12 bits
    always_comb begin
        sleep_ratio = 12'h190 << wakeup_code;
        if (rate_r[3:0] >= 4'hf) begin
            ratio = 12'h001;
        end else if (rate_r[3:0] >= 4'h6) begin
            ratio = 12'(12'h001 << (4'hf - rate_r[3:0]));
        end else begin
            ratio = 12'h200;
        end
        if (st_r == mss_pkg::MSS_ASLEEP) begin
            ratio = sleep_ratio;
        end
    end

    mss_decim #(.WIDTH(12)) u_decim (
        .clock    (clock),
        .rst      (rst),
        .base_stb (base_stb),
        .ratio    (ratio),
        .out_stb  (out_stb)
    );

    // detectors judge the full-rate stream, not the output words
    assign act_hit   = base_stb && over_thresh && act_armed;
    assign inact_hit = base_stb && still_timeout && inact_armed;

    // link alternation and autosleep
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            mss_pkg::MSS_AWAKE_ARMED_INACT: begin
                // pending activity blocks sleep entry
                if (inact_hit && link_en && !act_pend) begin
                    if (sleep_en && autosleep_en) begin
                        st_nxt = mss_pkg::MSS_ASLEEP;
                    end else begin
                        st_nxt = mss_pkg::MSS_AWAKE_ARMED_ACT;
                    end
                end else if (inact_hit && link_en) begin
                    st_nxt = mss_pkg::MSS_AWAKE_ARMED_ACT;
                end
            end
            mss_pkg::MSS_AWAKE_ARMED_ACT: begin
                if (act_hit || !link_en) begin
                    st_nxt = mss_pkg::MSS_AWAKE_ARMED_INACT;
                end
            end
            default: begin
                // wake restores configured rate
                if (act_hit || !link_en) begin
                    st_nxt = mss_pkg::MSS_AWAKE_ARMED_INACT;
                end
            end
        endcase
    end

    // register port; cause read clears, a new event wins the clear
    always_comb begin
        rate_nxt  = rate_r;
        fmt_nxt   = fmt_r;
        src_nxt   = src_r;
        rdata_nxt = reg_rdata;
        if (reg_wr && reg_addr == `MSS_ADDR_RATE) begin
            rate_nxt = reg_wdata;
        end else if (reg_wr && reg_addr == `MSS_ADDR_FORMAT) begin
            fmt_nxt = reg_wdata & 8'hef;
        end
        if (reg_rd) begin
            if (reg_addr == `MSS_ADDR_RATE) begin
                rdata_nxt = rate_r;
            end else if (reg_addr == `MSS_ADDR_INTSRC) begin
                rdata_nxt = src_r;
                src_nxt[`MSS_SRC_ACT]   = 1'b0;
                src_nxt[`MSS_SRC_INACT] = 1'b0;
            end else if (reg_addr == `MSS_ADDR_FORMAT) begin
                rdata_nxt = fmt_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
        // ready flag works in reduced power as well
        src_nxt[`MSS_SRC_DRDY] = out_stb && st_r != mss_pkg::MSS_ASLEEP;
        if (act_hit) begin
            src_nxt[`MSS_SRC_ACT] = 1'b1;
        end
        if (inact_hit) begin
            src_nxt[`MSS_SRC_INACT] = 1'b1;
        end
        stb_nxt = out_stb;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rate_r         <= `MSS_RATE_RST;
            fmt_r          <= `MSS_FORMAT_RST;
            src_r          <= 8'h00;
            reg_rdata      <= 8'h00;
            base_cnt_r     <= 32'h0;
            st_r           <= mss_pkg::MSS_AWAKE_ARMED_INACT;
            sample_stb     <= 1'b0;
            asleep         <= 1'b0;
            selftest_force <= 1'b0;
            act_armed      <= 1'b1;
            inact_armed    <= 1'b1;
        end else begin
            rate_r         <= rate_nxt;
            fmt_r          <= fmt_nxt;
            src_r          <= src_nxt;
            reg_rdata      <= rdata_nxt;
            base_cnt_r     <= base_cnt_nxt;
            st_r           <= st_nxt;
            sample_stb     <= stb_nxt;
            asleep         <= st_nxt == mss_pkg::MSS_ASLEEP;
            selftest_force <= fmt_nxt[`MSS_FMT_SELFTEST];
            // without link both detectors stay armed
            act_armed      <= !link_en ||
                              st_nxt != mss_pkg::MSS_AWAKE_ARMED_INACT;
            inact_armed    <= !link_en ||
                              st_nxt == mss_pkg::MSS_AWAKE_ARMED_INACT;
        end
    end

    property p_stim;
        @(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == `MSS_ADDR_FORMAT)
            |=> (selftest_force == $past(reg_wdata[7]));
    endproperty
    a_stim: assert property (p_stim) else $error("stimulus bit mismatch");

    property p_nosleep_pend;
        @(posedge clock) disable iff (rst)
        (st_r != mss_pkg::MSS_ASLEEP && act_pend) |=> !asleep;
    endproperty
    a_nosleep_pend: assert property (p_nosleep_pend)
        else $error("slept with activity pending");

    property p_sleep_entry;
        @(posedge clock) disable iff (rst)
        (inact_hit && link_en && sleep_en && autosleep_en && !act_pend &&
         st_r == mss_pkg::MSS_AWAKE_ARMED_INACT)
            |=> asleep && act_armed && !inact_armed;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("autosleep entry wrong");

    property p_wake;
        @(posedge clock) disable iff (rst)
        (act_hit && st_r == mss_pkg::MSS_ASLEEP && link_en)
            |=> !asleep && src_r[`MSS_SRC_ACT] && inact_armed && !act_armed;
    endproperty
    a_wake: assert property (p_wake) else $error("wake sequence wrong");

    property p_link_arm;
        @(posedge clock) disable iff (rst)
        (link_en && $past(link_en) && st_r ==
         mss_pkg::MSS_AWAKE_ARMED_INACT) |-> !act_hit;
    endproperty
    a_link_arm: assert property (p_link_arm)
        else $error("activity armed before inactivity");

    property p_act_set;
        @(posedge clock) disable iff (rst)
        act_hit |=> src_r[`MSS_SRC_ACT];
    endproperty
    a_act_set: assert property (p_act_set) else $error("activity lost");
endmodule
`default_nettype wire

// ==== hw/mss_decim.sv ====
// decimator: one shared sample-strobe stream divided down to the output rate
// assumes base strobe is a one-cycle pulse from the same clock
`timescale 1ns/1ps
`default_nettype none
module mss_decim #(
    parameter int unsigned WIDTH = 10
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             base_stb,
    input  wire logic [WIDTH-1:0] ratio,
    output logic                  out_stb
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic             out_nxt;

    // taps off the common stream, never a separate sampling clock
    always_comb begin
        cnt_nxt = cnt_r;
        out_nxt = 1'b0;
        if (base_stb) begin
            if (cnt_r + WIDTH'(1) >= ratio) begin
                cnt_nxt = '0;
                out_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r   <= '0;
            out_stb <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            out_stb <= out_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== hw/mss_pkg.sv ====
// types for the motion sleep and self-test controller
// assumes the constants header is included by the users
package mss_pkg;
    typedef enum logic [1:0] {
        MSS_AWAKE_ARMED_INACT,
        MSS_AWAKE_ARMED_ACT,
        MSS_ASLEEP
    } mss_state_t;
endpackage

// ==== verif/motion_sleep_and_selftest_ctrl_tb.sv ====
// bench for the control core: registers, sample rates, link and sleep
// assumes the core is built with a short base divider of 2 cycles
`timescale 1ns/1ps
`default_nettype none
`include "mss_consts.svh"
module motion_sleep_and_selftest_ctrl_tb;
    localparam int BD = 2;
    typedef struct {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] rd;
        logic       f;
    } mss_row_t;
    logic       clock;
    logic       rst;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       link_en;
    logic       autosleep_en;
    logic       sleep_en;
    logic [1:0] wakeup_code;
    logic       over_thresh;
    logic       still_timeout;
    logic [7:0] reg_rdata;
    logic       sample_stb;
    logic       asleep;
    logic       selftest_force;
    logic       act_armed;
    logic       inact_armed;
    logic [7:0] q;
    logic       ok;
    int         miscompares = 0;
    int         tests_run = 0;
    int         cycles = 0;
    int         n;
    // self-test setup: rate 0x0a normal power, scale_preserving_resolution range 3, stimulus
    mss_row_t rows [7] = '{
        '{8'h2c, 8'h0a, 8'h0a, 1'b0},
        '{8'h31, 8'h0b, 8'h0b, 1'b0},
        '{8'h31, 8'h8b, 8'h8b, 1'b1},
        '{8'h31, 8'hff, 8'hef, 1'b1},
        '{8'h2d, 8'h55, 8'h00, 1'b1},
        '{8'h2c, 8'h1f, 8'h1f, 1'b1},
        '{8'h31, 8'h0b, 8'h0b, 1'b0}
    };
    logic [7:0] pc [3] = '{8'h0f, 8'h0a, 8'h1a};  // full rate, normal and low-power 100 Hz
    int         pe [3] = '{BD, BD * 32, BD * 32};

    mss_ctrl #(.BASE_DIV(BD)) dut_u (
        .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .link_en(link_en),
        .autosleep_en(autosleep_en), .sleep_en(sleep_en),
        .wakeup_code(wakeup_code), .over_thresh(over_thresh),
        .still_timeout(still_timeout), .reg_rdata(reg_rdata),
        .sample_stb(sample_stb), .asleep(asleep),
        .selftest_force(selftest_force), .act_armed(act_armed),
        .inact_armed(inact_armed)
    );
    mss_host host_u (
        .clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .sample_stb(sample_stb), .selftest_force(selftest_force)
    );

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // first pulse after a change may come from the old ratio, so skip it
    task automatic period(input int e);
        int c;
        repeat (2) begin
            for (c = 0; c < 20000 && sample_stb !== 1'b1; c++) @(negedge clock);
            @(negedge clock);
        end
        for (c = 1; c < 20000 && sample_stb !== 1'b1; c++) @(negedge clock);
        chk(c[15:0], e[15:0]);
    endtask

    task automatic do_reset;
        rst = 1'b1;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        chk({asleep, selftest_force, act_armed, inact_armed}, 4'h3);
        host_u.xfer(1'b0, `MSS_ADDR_RATE, 8'h00, q);
        chk(q, `MSS_RATE_RST);
        host_u.xfer(1'b0, `MSS_ADDR_FORMAT, 8'h00, q);
        chk(q, `MSS_FORMAT_RST);
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        {link_en, autosleep_en, sleep_en, over_thresh, still_timeout} = 5'h0;
        wakeup_code = 2'b00;
        do_reset();
        foreach (rows[i]) begin
            host_u.xfer(1'b1, rows[i].a, rows[i].d, q);
            host_u.xfer(1'b0, rows[i].a, 8'h00, q);
            chk(q, rows[i].rd);
            chk(selftest_force, rows[i].f);
        end
        foreach (pc[i]) begin
            host_u.xfer(1'b1, `MSS_ADDR_RATE, pc[i], q);
            period(pe[i]);
        end
        host_u.selftest(10, ok);
        chk(ok, 1'b1);
        chk(selftest_force, 1'b0);
        host_u.xfer(1'b1, `MSS_ADDR_FORMAT, 8'hff, q);
        do_reset();
        // a non-default awake rate, so the restore on wake is visible
        host_u.xfer(1'b1, `MSS_ADDR_RATE, 8'h0c, q);
        {link_en, autosleep_en, sleep_en} = 3'h7;
        repeat (8) @(negedge clock);
        chk({act_armed, inact_armed}, 2'b01);
        still_timeout = 1'b1;
        for (n = 0; n < 64 && asleep !== 1'b1; n++) @(negedge clock);
        chk(asleep, 1'b1);
        chk({act_armed, inact_armed}, 2'b10);
        host_u.xfer(1'b0, `MSS_ADDR_INTSRC, 8'h00, q);
        chk(q & 8'h18, 8'h08);
        period(BD * 400);
        wakeup_code = 2'b01;
        period(BD * 800);
        wakeup_code = 2'b10;
        period(BD * 1600);
        wakeup_code = 2'b11;
        period(BD * 3200);
        // held for one base period only: the output rate never sees it
        still_timeout = 1'b0;
        over_thresh = 1'b1;
        repeat (BD) @(negedge clock);
        over_thresh = 1'b0;
        for (n = 0; n < 64 && asleep !== 1'b0; n++) @(negedge clock);
        chk(asleep, 1'b0);
        chk({act_armed, inact_armed}, 2'b01);
        period(BD * 8);
        still_timeout = 1'b1;
        repeat (64) @(negedge clock);
        chk(asleep, 1'b0);
        chk({act_armed, inact_armed}, 2'b10);
        // fresh activity, then cleared, so inactivity may put it to sleep
        still_timeout = 1'b0;
        over_thresh = 1'b1;
        repeat (BD) @(negedge clock);
        over_thresh = 1'b0;
        host_u.xfer(1'b0, `MSS_ADDR_INTSRC, 8'h00, q);
        chk(q & 8'h18, 8'h18);
        still_timeout = 1'b1;
        for (n = 0; n < 64 && asleep !== 1'b1; n++) @(negedge clock);
        chk(asleep, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire

// ==== verif/mss_host.sv ====
// host partner model: byte register reads and writes for the controller
// assumes strobes are sampled on the rising edge, one access at a time
`timescale 1ns/1ps
`default_nettype none
`include "mss_consts.svh"
// axis levels are stand-ins in lsb; arbitrary, not device figures
module mss_host #(
    parameter int AXIS_REST  = 40,
    parameter int AXIS_SHIFT = 300,
    parameter int ST_MIN     = 200
) (
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       sample_stb,
    input  wire logic       selftest_force,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one strobe cycle; a read of the cause register clears events
    // released lines show the inverse so stale values cannot match
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(negedge clock);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        q = reg_rdata;
    endtask

    // next output sample; the core has no data path, so the axis word
    // is a stand-in that moves by a fixed step while stimulus is on
    task automatic sample(output int s);
        do begin
            @(negedge clock);
        end while (sample_stb !== 1'b1);
        s = AXIS_REST + (selftest_force ? AXIS_SHIFT : 0);
    endtask

    // host self-test: baseline, stimulus on, settle, same count again
    task automatic selftest(input int n, output logic ok);
        logic signed [23:0] acc_off;
        logic signed [23:0] acc_on;
        logic signed [23:0] diff;
        logic [7:0]         dq;
        int                 s;
        int                 i;
        acc_off = '0;
        acc_on  = '0;
        xfer(1'b1, `MSS_ADDR_RATE, 8'h0a, dq);
        xfer(1'b1, `MSS_ADDR_FORMAT, 8'h0b, dq);
        for (i = 0; i < n; i++) begin
            sample(s);
            acc_off += 24'(s);
        end
        xfer(1'b1, `MSS_ADDR_FORMAT, 8'h8b, dq);
        for (i = 0; i < 4; i++) begin
            sample(s);
        end
        for (i = 0; i < n; i++) begin
            sample(s);
            acc_on += 24'(s);
        end
        xfer(1'b1, `MSS_ADDR_FORMAT, 8'h0b, dq);
        diff = (acc_on - acc_off) / 24'(n);
        // only the minimum is judged; a large change is no failure
        ok = diff >= 24'(ST_MIN);
    endtask
endmodule
`default_nettype wire
